// [hdl/csd_pkg.sv]
// Purpose: Shared constants for the clock start-up delay selector
// Assumes: System clock of 125 MHz, AXI4-Lite register access
// Notes:   Millisecond delays are converted to system clock counts here

package csd_pkg;

   // ==========================================================
   // Clock and delay times
   localparam real         CSD_CLK_MHZ      = 125.0;
   localparam real         CSD_T_SHORT_MS   = 4.1;
   localparam real         CSD_T_LONG_MS    = 65.0;
   localparam real         CSD_T_EXTRA_MS   = 4.0;
   // Least times round up to whole cycles
   localparam logic [23:0] CSD_CYC_SHORT    = 24'($ceil(CSD_T_SHORT_MS * 1000.0 * CSD_CLK_MHZ));
   localparam logic [23:0] CSD_CYC_LONG     = 24'($ceil(CSD_T_LONG_MS * 1000.0 * CSD_CLK_MHZ));
   localparam logic [23:0] CSD_CYC_EXTRA    = 24'($ceil(CSD_T_EXTRA_MS * 1000.0 * CSD_CLK_MHZ));

   // ==========================================================
   // Source clock cycle counts
   localparam logic [15:0] CSD_CK_6         = 16'h0006;
   localparam logic [15:0] CSD_CK_14        = 16'h000E;
   localparam logic [15:0] CSD_CK_258       = 16'h0102;
   localparam logic [15:0] CSD_CK_1K        = 16'h0400;
   localparam logic [15:0] CSD_CK_16K       = 16'h4000;
   localparam logic [15:0] CSD_CK_32K       = 16'h8000;
   localparam logic [15:0] CSD_CK_NONE      = 16'h0000;

   // ==========================================================
   // Source kinds and start-up codes
   localparam logic [1:0]  CSD_SRC_HF_XTAL  = 2'h0;
   localparam logic [1:0]  CSD_SRC_LF_XTAL  = 2'h1;
   localparam logic [1:0]  CSD_SRC_EXT_CLK  = 2'h2;
   localparam logic [1:0]  CSD_SUT_00       = 2'h0;
   localparam logic [1:0]  CSD_SUT_01       = 2'h1;
   localparam logic [1:0]  CSD_SUT_10       = 2'h2;
   localparam logic [1:0]  CSD_SUT_11       = 2'h3;

   typedef enum logic [1:0] {CSD_MS_NONE, CSD_MS_SHORT, CSD_MS_LONG, CSD_MS_EXTRA} csd_ms_t;

   // ==========================================================
   // Register map (byte offsets)
   localparam logic [7:0]  CSD_OFS_CTRL     = 8'h00;
   localparam logic [7:0]  CSD_OFS_STATUS   = 8'h04;
   localparam logic [7:0]  CSD_OFS_ENABLE   = 8'h08;

   // CTRL fields
   localparam int          CSD_CTRL_SUT_LO  = 0;
   localparam int          CSD_CTRL_LSB     = 2;
   localparam int          CSD_CTRL_KIND_LO = 3;
   localparam int          CSD_CTRL_FROMRST = 5;
   localparam int          CSD_CTRL_GO      = 8;
   localparam logic        CSD_FROMRST_RST  = 1'b1;

   // STATUS fields
   localparam int          CSD_ST_READY     = 0;
   localparam int          CSD_ST_BUSY      = 1;
   localparam int          CSD_ST_INVALID   = 2;
   localparam int          CSD_ST_LF_EN     = 3;
   localparam int          CSD_ST_EXT_EN    = 4;

   // ENABLE fields
   localparam int          CSD_EN_HF        = 0;
   localparam int          CSD_EN_LF        = 1;
   localparam int          CSD_EN_EXT       = 2;

   // AXI responses
   localparam logic [1:0]  CSD_RESP_OKAY    = 2'h0;
   localparam logic [1:0]  CSD_RESP_SLVERR  = 2'h2;

endpackage

// [hdl/csd_decode.sv]
// Purpose: Maps source kind and start-up code to cycle counts and delays
// Assumes: Inputs stable while a count runs
// Notes:   Pure combinational lookup

`timescale 1ns/1ps

module csd_decode
   import csd_pkg::*;
(
   input  wire logic [1:0]  src_kind,
   input  wire logic        sel_lsb,
   input  wire logic [1:0]  startup,
   input  wire logic        rst_pin_dis,
   output csd_ms_t          ms_sel,
   output logic      [15:0] pd_cycles,
   output logic      [15:0] rst_cycles,
   output logic             valid
);

   // ==========================================================
   // Table lookup
   always_comb begin
      ms_sel     = CSD_MS_NONE;
      pd_cycles  = CSD_CK_NONE;
      rst_cycles = CSD_CK_14;
      valid      = 1'b1;
      unique case (src_kind)
         CSD_SRC_HF_XTAL: begin
            pd_cycles = sel_lsb ? CSD_CK_16K : CSD_CK_1K;
            unique case ({sel_lsb, startup})
               3'h0: begin pd_cycles = CSD_CK_258; ms_sel = CSD_MS_SHORT; end
               3'h1: begin pd_cycles = CSD_CK_258; ms_sel = CSD_MS_LONG; end
               3'h2: valid = !rst_pin_dis;
               3'h3: ms_sel = CSD_MS_SHORT;
               3'h4: pd_cycles = CSD_CK_1K;
               3'h5: begin pd_cycles = CSD_CK_1K; ms_sel = CSD_MS_LONG; end
               3'h6: ms_sel = CSD_MS_SHORT;
               3'h7: ms_sel = CSD_MS_LONG;
            endcase
            // Bit-1 code 00 is the 1K long-delay row; 01 is 16K no extra delay
            if ({sel_lsb, startup} == 3'h4) begin
               ms_sel = CSD_MS_LONG;
            end
            if ({sel_lsb, startup} == 3'h5) begin
               pd_cycles = CSD_CK_16K;
               ms_sel    = CSD_MS_NONE;
               valid     = !rst_pin_dis;
            end
         end
         CSD_SRC_LF_XTAL: begin
            rst_cycles = CSD_CK_NONE;                              // Only a time delay after reset
            unique case (startup)
               CSD_SUT_00: begin pd_cycles = CSD_CK_1K; ms_sel = CSD_MS_SHORT; end
               CSD_SUT_01: begin pd_cycles = CSD_CK_1K; ms_sel = CSD_MS_LONG; end
               CSD_SUT_10: begin pd_cycles = CSD_CK_32K; ms_sel = CSD_MS_LONG; end
               CSD_SUT_11: valid = 1'b0;
            endcase
         end
         CSD_SRC_EXT_CLK: begin
            pd_cycles = CSD_CK_6;
            unique case (startup)
               CSD_SUT_00: ms_sel = rst_pin_dis ? CSD_MS_EXTRA : CSD_MS_NONE;
               CSD_SUT_01: ms_sel = CSD_MS_SHORT;
               CSD_SUT_10: ms_sel = CSD_MS_LONG;
               CSD_SUT_11: valid = 1'b0;
            endcase
         end
         default: begin
            valid = 1'b0;                                          // Unused kind code
         end
      endcase
   end

endmodule

// [hdl/csd_counter.sv]
// Purpose: Counts ticks up to a loaded limit and pulses done
// Assumes: tick is synchronous to sys_clk
// Notes:   A zero limit finishes one cycle after start

`timescale 1ns/1ps

module csd_counter (
   input  wire logic        sys_clk,
   input  wire logic        reset,
   input  wire logic        start,
   input  wire logic [23:0] limit,
   input  wire logic        tick,
   output logic             busy,
   output logic             done
);

   logic [23:0] count;
   logic [23:0] next_count;

   assign next_count = count + 24'h000001;

   // ==========================================================
   // Count process
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         count <= 24'h000000;
         busy  <= 1'b0;
         done  <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            count <= 24'h000000;
            busy  <= (limit != 24'h000000);
            done  <= (limit == 24'h000000);
         end else if (busy && tick) begin
            count <= next_count;
            if (next_count == limit) begin
               busy <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end

endmodule

// [hdl/csd_top.sv]
// Purpose: Start-up delay selection for crystal, low-frequency crystal and external clock sources
// Assumes: src_clk_tick marks one selected source clock edge, synchronous to sys_clk
// Notes:   Selection register is loaded from the fuse inputs at reset, then software may overwrite it
//
// Notes on behaviour
// - The crystal start-up delay is picked from the select low bit and the two-bit start-up field.
// - Select bit 0 with field 00 or 01 counts 258 cycles, reset adds 14 cycles plus 4.1 ms or 65 ms.
// - Bit 0 field 10/11 and bit 1 field 00 count 1024 cycles, with 14, 14+4.1 ms and 14+65 ms after reset.
// - Bit 1 with field 01/10/11 counts 16384 cycles, with 14, 14+4.1 ms and 14+65 ms after reset.
// - Crystal codes bit 0 field 10 and bit 1 field 01 are refused while the reset pin disable fuse is set.
// - Low-frequency crystal field 00 and 01 count 1024 cycles and add 4.1 ms or 65 ms after reset.
// - Low-frequency crystal field 10 counts 32768 cycles and adds 65 ms after reset.
// - External clock counts 6 cycles; codes 00, 01, 10 add 14, 14+4.1 ms, 14+65 ms after reset.
// - The async timer may start the low-frequency oscillator only if the crystal is off or external is off.
// - The async timer may enable the external clock only if neither crystal oscillator runs.
// - External clock code 00 adds about 4 ms after reset when the reset pin disable fuse is set.
//
// The AXI4-Lite slave port and the address map were decided locally.

`timescale 1ns/1ps

module csd_top
   import csd_pkg::*;
#(
   parameter logic [23:0] P_CYC_SHORT = CSD_CYC_SHORT,
   parameter logic [23:0] P_CYC_LONG  = CSD_CYC_LONG,
   parameter logic [23:0] P_CYC_EXTRA = CSD_CYC_EXTRA
)(
   input  wire logic        sys_clk,
   input  wire logic        reset,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Fuses, source clock and async timer
   input  wire logic [1:0]  src_kind_fuses,
   input  wire logic        src_sel_lsb_fuse,
   input  wire logic [1:0]  startup_fuse_bits,
   input  wire logic        reset_pin_disable_fuse,
   input  wire logic        src_clk_tick,
   input  wire logic        timer_lf_req,
   input  wire logic        timer_ext_req,
   output logic             startup_ready,
   output logic             lf_osc_timer_en,
   output logic             ext_clock_input_en
);

   typedef enum logic [1:0] {CSD_IDLE, CSD_SRC, CSD_MS} csd_state_t;

   // ==========================================================
   // Declarations
   csd_state_t  state;
   logic [1:0]  src_sel_field;
   logic        src_sel_lsb_field;
   logic [1:0]  startup_field;
   logic        from_reset;
   logic        hf_running;
   logic        lf_running;
   logic        ext_enabled;
   logic        invalid;
   logic        go;
   csd_ms_t     ms_sel;
   csd_ms_t     ms_lat;
   logic [15:0] pd_cycles;
   logic [15:0] rst_cycles;
   logic        cfg_valid;
   logic        src_start;
   logic [23:0] src_limit;
   logic        src_busy;
   logic        src_done;
   logic        ms_start;
   logic [23:0] ms_limit;
   logic        ms_busy;
   logic        ms_done;
   logic        aw_held;
   logic        w_held;
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        wr_do;
   logic        rd_do;
   logic        next_aw_held;
   logic        next_w_held;
   logic        next_bvalid;
   logic        next_rvalid;

   // Address decode, shared by the read and write paths
   function automatic logic csd_mapped(input logic [7:0] addr);
      csd_mapped = (addr == CSD_OFS_CTRL) || (addr == CSD_OFS_STATUS) || (addr == CSD_OFS_ENABLE);
   endfunction

   // ==========================================================
   // Delay lookup
   csd_decode u_decode (
      .src_kind    (src_sel_field),
      .sel_lsb     (src_sel_lsb_field),
      .startup     (startup_field),
      .rst_pin_dis (reset_pin_disable_fuse),
      .ms_sel      (ms_sel),
      .pd_cycles   (pd_cycles),
      .rst_cycles  (rst_cycles),
      .valid       (cfg_valid)
   );

   // ==========================================================
   // Counters: source cycles, then system cycles for the millisecond part
   csd_counter u_src_cnt (
      .sys_clk (sys_clk),
      .reset   (reset),
      .start   (src_start),
      .limit   (src_limit),
      .tick    (src_clk_tick),
      .busy    (src_busy),
      .done    (src_done)
   );

   csd_counter u_ms_cnt (
      .sys_clk (sys_clk),
      .reset   (reset),
      .start   (ms_start),
      .limit   (ms_limit),
      .tick    (1'b1),
      .busy    (ms_busy),
      .done    (ms_done)
   );

   // Start terms: power-down count, or the fixed cycles before a reset time delay
   assign src_start = go && cfg_valid && (state == CSD_IDLE);
   assign src_limit = {8'h00, from_reset ? rst_cycles : pd_cycles};
   assign ms_start  = (state == CSD_SRC) && src_done && from_reset && (ms_lat != CSD_MS_NONE);

   // Millisecond count chosen by the latched selection
   always_comb begin
      unique case (ms_lat)
         CSD_MS_NONE:  ms_limit = 24'h000000;
         CSD_MS_SHORT: ms_limit = P_CYC_SHORT;
         CSD_MS_LONG:  ms_limit = P_CYC_LONG;
         CSD_MS_EXTRA: ms_limit = P_CYC_EXTRA;
      endcase
   end

   // ==========================================================
   // Start-up sequencer
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state         <= CSD_IDLE;
         ms_lat        <= CSD_MS_NONE;
         startup_ready <= 1'b0;
         invalid       <= 1'b0;
      end else begin
         unique case (state)
            CSD_IDLE: begin
               if (go && !cfg_valid) begin
                  invalid <= 1'b1;
               end else if (go) begin
                  invalid       <= 1'b0;
                  startup_ready <= 1'b0;                             // Ready clears when a count starts
                  ms_lat        <= ms_sel;                           // Freeze time delay for this run
                  state         <= CSD_SRC;
               end
            end
            CSD_SRC: begin
               if (src_done && ms_start) begin
                  state <= CSD_MS;
               end else if (src_done) begin
                  startup_ready <= 1'b1;
                  state         <= CSD_IDLE;
               end
            end
            CSD_MS: begin
               if (ms_done) begin
                  startup_ready <= 1'b1;
                  state         <= CSD_IDLE;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // Async timer grants, gated by which sources are running
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         lf_osc_timer_en    <= 1'b0;
         ext_clock_input_en <= 1'b0;
      end else begin
         lf_osc_timer_en    <= timer_lf_req && (!hf_running || !ext_enabled);
         ext_clock_input_en <= timer_ext_req && !hf_running && !lf_running;
      end
   end

   // ==========================================================
   // AXI4-Lite handshakes; one write and one read at a time
   assign wr_do        = aw_held && w_held && !s_axi_bvalid;
   assign rd_do        = s_axi_arvalid && s_axi_arready;
   assign next_aw_held = aw_held ? !wr_do : (s_axi_awvalid && s_axi_awready);
   assign next_w_held  = w_held ? !wr_do : (s_axi_wvalid && s_axi_wready);
   assign next_bvalid  = s_axi_bvalid ? !s_axi_bready : wr_do;
   assign next_rvalid  = s_axi_rvalid ? !s_axi_rready : rd_do;

   // Address and data may arrive in either order; each is held until the write is done
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= 8'h00;
         w_data        <= 32'h00000000;
         w_strb        <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= CSD_RESP_OKAY;
      end else begin
         aw_held       <= next_aw_held;
         w_held        <= next_w_held;
         s_axi_awready <= !next_aw_held && !next_bvalid;
         s_axi_wready  <= !next_w_held && !next_bvalid;
         s_axi_bvalid  <= next_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_do) begin
            s_axi_bresp <= csd_mapped(aw_addr) ? CSD_RESP_OKAY : CSD_RESP_SLVERR;
         end
      end
   end

   // Register writes; the selection register takes the fuse copy at reset
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         src_sel_field     <= src_kind_fuses;
         src_sel_lsb_field <= src_sel_lsb_fuse;
         startup_field     <= startup_fuse_bits;
         from_reset        <= CSD_FROMRST_RST;
         hf_running        <= 1'b0;
         lf_running        <= 1'b0;
         ext_enabled       <= 1'b0;
         go                <= 1'b0;
      end else begin
         go <= 1'b0;
         if (wr_do && aw_addr == CSD_OFS_CTRL) begin
            if (w_strb[0]) begin
               startup_field     <= w_data[CSD_CTRL_SUT_LO +: 2];
               src_sel_lsb_field <= w_data[CSD_CTRL_LSB];
               src_sel_field     <= w_data[CSD_CTRL_KIND_LO +: 2];
               from_reset        <= w_data[CSD_CTRL_FROMRST];
            end
            go <= w_strb[1] && w_data[CSD_CTRL_GO];              // Self-clearing start strobe
         end
         if (wr_do && aw_addr == CSD_OFS_ENABLE && w_strb[0]) begin
            hf_running  <= w_data[CSD_EN_HF];
            lf_running  <= w_data[CSD_EN_LF];
            ext_enabled <= w_data[CSD_EN_EXT];
         end
      end
   end

   // Reads; unmapped addresses answer zero with SLVERR
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= CSD_RESP_OKAY;
      end else begin
         s_axi_arready <= !next_rvalid;
         s_axi_rvalid  <= next_rvalid;
         if (rd_do) begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= csd_mapped(s_axi_araddr) ? CSD_RESP_OKAY : CSD_RESP_SLVERR;
            unique case (s_axi_araddr)
               CSD_OFS_CTRL: begin
                  s_axi_rdata[CSD_CTRL_SUT_LO +: 2]  <= startup_field;
                  s_axi_rdata[CSD_CTRL_LSB]          <= src_sel_lsb_field;
                  s_axi_rdata[CSD_CTRL_KIND_LO +: 2] <= src_sel_field;
                  s_axi_rdata[CSD_CTRL_FROMRST]      <= from_reset;
               end
               CSD_OFS_STATUS: begin
                  s_axi_rdata[CSD_ST_READY]   <= startup_ready;
                  s_axi_rdata[CSD_ST_BUSY]    <= (state != CSD_IDLE) || src_busy || ms_busy;
                  s_axi_rdata[CSD_ST_INVALID] <= invalid;
                  s_axi_rdata[CSD_ST_LF_EN]   <= lf_osc_timer_en;
                  s_axi_rdata[CSD_ST_EXT_EN]  <= ext_clock_input_en;
               end
               CSD_OFS_ENABLE: begin
                  s_axi_rdata[CSD_EN_HF]  <= hf_running;
                  s_axi_rdata[CSD_EN_LF]  <= lf_running;
                  s_axi_rdata[CSD_EN_EXT] <= ext_enabled;
               end
               default: begin
                  s_axi_rdata <= 32'h00000000;
               end
            endcase
         end
      end
   end

endmodule

// [dv/csd_src_model.sv]
// Purpose: Source oscillator model, one tick per period
// Assumes: Period of 1 to 3 system cycles
// Notes:   Silent while stopped, like an oscillator not yet enabled
`timescale 1ns/1ps
module csd_src_model (
   input  wire logic       sys_clk,
   input  wire logic       run,
   input  wire logic [1:0] period,
   output logic            src_clk_tick
);
   logic [1:0] cnt = 2'h0;
   // ==========
   // Divider
   // Restarts on stop so that a new run begins with a full period
   always_ff @(posedge sys_clk) begin
      cnt          <= (!run || cnt == period - 2'h1) ? 2'h0 : cnt + 2'h1;
      src_clk_tick <= run && cnt == period - 2'h1;
   end
endmodule

// [dv/csd_top_chk.sv]
// Purpose: Port checks for the start-up delay selector
// Assumes: Enables are internal, so grants are tied to requests only
// Notes:   Bound to the top module at the foot
`timescale 1ns/1ps
module csd_top_chk (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic startup_ready,
   input wire logic lf_osc_timer_en,
   input wire logic ext_clock_input_en,
   input wire logic timer_lf_req,
   input wire logic timer_ext_req
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   // ==========
   // Bus walks
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_wr_answer;
      !s_axi_bvalid ##1 s_axi_bvalid;
   endsequence
   a_wr_lat: assert property (s_wr_take |=> s_wr_answer) else $error("write answer off");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
   a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken");
   a_rd_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid dropped");
   a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken");
   // ==========
   // Grants and reset
   a_lf_grant: assert property (lf_osc_timer_en |-> $past(timer_lf_req)) else $error("lf unasked");
   a_ext_grant: assert property (ext_clock_input_en |-> $past(timer_ext_req)) else $error("ext unasked");
   a_reset_quiet: assert property (disable iff (1'b0) reset |=> !startup_ready && !lf_osc_timer_en)
      else $error("live in reset");
endmodule
bind csd_top csd_top_chk u_chk (.sys_clk, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .startup_ready,
   .lf_osc_timer_en, .ext_clock_input_en, .timer_lf_req, .timer_ext_req);

// [dv/csd_top_tb_top.sv]
// Purpose: Self-checking bench for the start-up delay selector
// Assumes: Millisecond counts shortened to 50, 200 and 40 cycles
// Notes:   Source ticks come from the oscillator model
`timescale 1ns/1ps
module csd_top_tb_top
   import csd_pkg::*;
;
   localparam logic [23:0] SH = 24'h000032;
   localparam logic [23:0] LG = 24'h0000C8;
   localparam logic [23:0] EX = 24'h000028;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp, src_kind_fuses = 2'h2, startup_fuse_bits = 2'h1, per = 2'h1;
   logic        sys_clk = 1'b0, reset = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, src_sel_lsb_fuse = 1'b1, reset_pin_disable_fuse = 1'b0;
   logic        timer_lf_req = 1'b0, timer_ext_req = 1'b0, run = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid, src_clk_tick, startup_ready, lf_osc_timer_en, ext_clock_input_en;
   logic [15:0] rnd = 16'h188D;
   // Rows are {fuse disable, from reset, kind, select bit, code}; refused rows last
   logic [6:0]  tbl [24] = '{7'h00, 7'h02, 7'h05, 7'h20, 7'h21, 7'h22, 7'h23, 7'h24, 7'h26, 7'h27, 7'h63, 7'h08,
                              7'h0A, 7'h29, 7'h10, 7'h30, 7'h70, 7'h31, 7'h32, 7'h0B, 7'h33, 7'h42, 7'h45, 7'h18};
   int          errors = 0, check_count = 0;
   csd_top #(.P_CYC_SHORT(SH), .P_CYC_LONG(LG), .P_CYC_EXTRA(EX)) DUT (.*);
   csd_src_model SRC (.sys_clk, .run, .period(per), .src_clk_tick);
   // Clock
   initial forever #4 sys_clk = ~sys_clk;
   // ==========
   // Helpers
   task automatic end_sim;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One edge; a hang past the bound ends the run
   task automatic step(inout int k);
      @(posedge sys_clk);
      k++;
      if (k > 40000) begin
         errors++;
         end_sim();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         step(k);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      // bready stays high between writes so that back-to-back calls never drive it twice in one step
      chk("bresp", s_axi_bresp, CSD_RESP_OKAY);
   endtask
   task automatic rd_reg(input logic [7:0] a);
      int k;
      k = 0;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         step(k);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
   endtask
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // Expected count and millisecond cycles, -1 when refused
   function automatic int exp_n(input logic [5:0] c, input logic dis, output int m);
      exp_n = -1;
      case (c[4:3])
         2'h0: begin
            m = c[2:0] % 3 == 0 ? SH : c[2:0] % 3 == 1 ? LG : 0;
            if (!(dis && (c[2:0] == 3'h2 || c[2:0] == 3'h5))) exp_n = c[2:0] < 2 ? 258 : c[2:0] < 5 ? 1024 : 16384;
         end
         2'h1: begin
            m = c[1:0] == 2'h0 ? SH : LG;
            if (c[1:0] != 2'h3) exp_n = c[1] ? 32768 : 1024;
         end
         2'h2: begin
            m = c[1:0] == 2'h1 ? SH : c[1:0] == 2'h2 ? LG : dis ? EX : 0;
            if (c[1:0] != 2'h3) exp_n = 6;
         end
         default: m = 0;
      endcase
      if (c[5]) exp_n = exp_n < 0 ? -1 : c[4:3] == 2'h1 ? 0 : 14;
      else m = 0;
   endfunction
   // Slow ticks only on short counts, keeping the run bounded
   task automatic run_case(input logic [6:0] e);
      int k, t, cy, n, m, lo;
      k = 0;
      t = 0;
      cy = 0;
      n = exp_n(e[5:0], e[6], m);
      rnd = lfsr(rnd);
      per <= n > 1024 ? 2'h1 : 2'h1 + 2'(rnd % 16'h3);
      reset_pin_disable_fuse <= e[6];
      wr(CSD_OFS_CTRL, {23'h0, 1'b1, 2'h0, e[5:0]});
      if (n < 0) begin
         rd_reg(CSD_OFS_STATUS);
         chk("refused go", rd[2:0], 3'h5);
         return;
      end
      while (startup_ready === 1'b1) step(k);
      run <= 1'b1;
      while (startup_ready !== 1'b1) begin
         step(k);
         cy++;
         t += int'(src_clk_tick);
      end
      run <= 1'b0;
      lo = e[5] ? n * per + m - per : n;
      cy = e[5] ? cy : t;
      chk("delay window", cy >= lo && cy <= lo + (e[5] ? 4 * per + 8 : 3), 1);
   endtask
   // ==========
   // Main sequence
   initial begin
      repeat (12) @(posedge sys_clk);
      reset <= 1'b0;
      rd_reg(CSD_OFS_CTRL);
      chk("ctrl fuse copy", rd[5:0], 6'h35);
      rd_reg(CSD_OFS_STATUS);
      chk("status reset", rd[4:0], 5'h00);
      rd_reg(8'h0C);
      chk("unmapped resp", rsp, CSD_RESP_SLVERR);
      chk("unmapped data", rd, 32'h0);
      for (int i = 0; i < 32; i++) begin
         rnd = lfsr(rnd);
         wr(CSD_OFS_ENABLE, {29'h0, i[2:0]});
         timer_lf_req  <= rnd[0];
         timer_ext_req <= rnd[1];
         repeat (2) @(posedge sys_clk);
         chk("lf grant", lf_osc_timer_en, rnd[0] & (!i[0] | !i[2]));
         chk("ext grant", ext_clock_input_en, rnd[1] & !i[0] & !i[1]);
      end
      foreach (tbl[j]) run_case(tbl[j]);
      end_sim();
   end
endmodule
